// ---- src/dcwb_consts.svh ----
// Offsets, field positions, reset values and masks of the configuration word bank
`ifndef DCWB_CONSTS_SVH
`define DCWB_CONSTS_SVH

`define DCWB_ADDR_W 16
`define DCWB_OFF_CFG_CTRL 16'hf200
`define DCWB_OFF_IDENT 16'hf220
`define DCWB_OFF_KEY 16'hf230
`define DCWB_OFF_WORD0 16'hf240
`define DCWB_OFF_WORD1 16'hf244
`define DCWB_OFF_WORD2 16'hf248
`define DCWB_OFF_WORD3 16'hf24c
`define DCWB_OFF_MODDIS 16'hf250
`define DCWB_OFF_PROG 16'hf254

`define DCWB_CFG_CTRL_RST 32'h0000000b
`define DCWB_CFG_CTRL_MASK 32'h0000300b
`define DCWB_KEY_RST 32'h00000000
`define DCWB_MODDIS_RST 32'h00000000

`define DCWB_BIT_CODE_PROT 28
`define DCWB_BIT_BOOT_WP 24
`define DCWB_BIT_SCAN_EN 2
`define DCWB_BIT_ONE_SHOT 28
`define DCWB_BIT_MOD_LOCK 12
`define DCWB_BIT_PIN_LOCK 13
`define DCWB_BIT_CTRL_SCAN 3
`define DCWB_BIT_TDO_EN 0

`define DCWB_W0_FORCE1 32'h6ef803e0
`define DCWB_W0_FORCE0 32'h80000000
`define DCWB_W0_PWP_TOP 32'h00060000
`define DCWB_W1_MASK 32'h03dff7a7
`define DCWB_W2_MASK 32'h00078777
`define DCWB_W3_MASK 32'hf000ffff
`define DCWB_W3_FORCE0 32'h0fff0000

`endif

// ---- src/dcwb_pkg.sv ----
// Types of the configuration word bank
package dcwb_pkg;
    typedef enum logic [1:0] {DCWB_IDLE, DCWB_ACK} dcwb_bus_state_t;
    typedef logic [1:0] dcwb_word_sel_t;
endpackage

// ---- src/dcwb_word_mem.sv ----
// Four-word store of the non-volatile configuration words
`timescale 1ns/1ns
`default_nettype none
module dcwb_word_mem
    import dcwb_pkg::*;
(
    input wire logic clk_i, // System clock
    input wire logic wr_i, // Programming write strobe
    input wire dcwb_word_sel_t wr_sel_i, // Word written
    input wire logic [31:0] wr_data_i, // Word value
    input wire dcwb_word_sel_t rd_sel_i, // Word read
    output logic [31:0] rd_data_o, // Registered read data
    output logic [127:0] words_o // All words, for decode
);
    logic [31:0] mem_r [4];
    always_ff @(posedge clk_i) begin
        if (wr_i) begin
            mem_r[wr_sel_i] <= wr_data_i;
        end
        rd_data_o <= mem_r[rd_sel_i];
    end
    genvar g;
    for (g = 0; g < 4; g++) begin : g_out
        assign words_o[g*32 +: 32] = mem_r[g];
    end
endmodule // dcwb_word_mem
`default_nettype wire

// ---- src/dcwb_bank.sv ----
// Configuration word bank with system configuration registers on Wishbone
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "dcwb_consts.svh"
module dcwb_bank
    import dcwb_pkg::*;
#(
    parameter logic [3:0] SILICON_VERSION = 4'h1, // Arbitrary value
    parameter logic [27:0] PART_CODE = 28'h0000123, // Arbitrary value
    parameter bit BIG_FLASH = 1'b1 // 256 KB flash variant
)(
    input wire logic clk_i, // 25 MHz clock
    input wire logic rst_i, // Synchronous reset, high
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write
    input wire logic [15:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte lanes
    input wire logic [31:0] wb_dat_i, // Write data
    output logic [31:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Acknowledge
    output logic wb_err_o, // Unmapped address
    input wire logic prog_wr_i, // Programmer word write
    input wire logic [1:0] prog_sel_i, // Programmer word number
    input wire logic [31:0] prog_data_i, // Programmer word value
    input wire logic ext_access_i, // External programmer access request
    input wire logic boot_wr_req_i, // Boot flash write attempt by code
    output logic ext_access_ok_o, // External access granted
    output logic boot_wr_ok_o, // Boot flash write granted
    output logic scan_port_enable_o, // Scan port enabled
    output logic pin_select_lock_o, // Pin select lock
    output logic test_out_drive_enable_o, // Test output drive enable
    output logic module_disable_lock_o, // Module disable lock
    output logic [31:0] module_disable_o, // Module disable bits
    output logic [31:0] unlock_key_o // Unlock key value
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        dcwb_bus_state_t st;
        logic [31:0] dat;
        logic err;
        logic [31:0] ctrl;
        logic [31:0] key;
        logic [31:0] moddis;
        logic lock_seen;
        logic ext_ok;
        logic boot_ok;
    } dcwb_state_t;

    dcwb_state_t s_r, s_nxt;
    logic [31:0] mem_rd;
    logic [127:0] words;
    logic [31:0] w0, w3;
    logic [1:0] rd_sel;

    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic is_word(input logic [15:0] a);
        return a[15:4] == 12'(`DCWB_OFF_WORD0 >> 4) && a[1:0] == 2'b00;
    endfunction

    // Reserved bits of word 0 read at their forced values; unimplemented ones as zero
    function automatic logic [31:0] word_view(input logic [1:0] sel, input logic [31:0] raw);
        logic [31:0] v;
        case (sel)
            2'd0: begin
                v = (raw | `DCWB_W0_FORCE1) & ~`DCWB_W0_FORCE0;
                if (!BIG_FLASH) begin
                    v = v & ~`DCWB_W0_PWP_TOP;
                end
            end
            2'd1: v = raw & `DCWB_W1_MASK;
            2'd2: v = raw & `DCWB_W2_MASK;
            default: v = raw & `DCWB_W3_MASK;
        endcase
        return v;
    endfunction

    // ****************************************
    // Word store
    // ****************************************
    assign rd_sel = wb_adr_i[3:2];
    dcwb_word_mem u_mem (
        .clk_i(clk_i),
        .wr_i(prog_wr_i),
        .wr_sel_i(prog_sel_i),
        .wr_data_i(prog_data_i),
        .rd_sel_i(rd_sel),
        .rd_data_o(mem_rd),
        .words_o(words)
    );

    // Decoded views of the words that drive control
    always_comb begin
        w0 = word_view(2'd0, words[31:0]);
        w3 = word_view(2'd3, words[127:96]);
    end

    // ****************************************
    // Bus and control
    // ****************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.ext_ok = ext_access_i & w0[`DCWB_BIT_CODE_PROT];
        s_nxt.boot_ok = boot_wr_req_i & w0[`DCWB_BIT_BOOT_WP];
        s_nxt.ctrl[`DCWB_BIT_CTRL_SCAN] = w0[`DCWB_BIT_SCAN_EN];
        if (s_r.ctrl[`DCWB_BIT_MOD_LOCK] && w3[`DCWB_BIT_ONE_SHOT]) begin
            s_nxt.lock_seen = 1'b1;
        end
        case (s_r.st)
            DCWB_IDLE: begin
                if (wb_cyc_i && wb_stb_i) begin
                    s_nxt.st = DCWB_ACK;
                    s_nxt.err = 1'b0;
                    s_nxt.dat = 32'h0;
                    case (wb_adr_i)
                        `DCWB_OFF_CFG_CTRL: begin
                            s_nxt.dat = s_r.ctrl;
                            if (wb_we_i) begin
                                s_nxt.ctrl = lane_merge(s_r.ctrl, wb_dat_i, wb_sel_i)
                                             & `DCWB_CFG_CTRL_MASK;
                                s_nxt.ctrl[`DCWB_BIT_CTRL_SCAN] = w0[`DCWB_BIT_SCAN_EN];
                                if (s_r.lock_seen || (s_r.ctrl[`DCWB_BIT_MOD_LOCK]
                                                     && w3[`DCWB_BIT_ONE_SHOT])) begin
                                    s_nxt.ctrl[`DCWB_BIT_MOD_LOCK] = 1'b1;
                                end
                            end
                        end
                        `DCWB_OFF_IDENT: s_nxt.dat = {SILICON_VERSION, PART_CODE};
                        `DCWB_OFF_KEY: begin
                            s_nxt.dat = s_r.key;
                            if (wb_we_i) begin
                                s_nxt.key = lane_merge(s_r.key, wb_dat_i, wb_sel_i);
                            end
                        end
                        `DCWB_OFF_MODDIS: begin
                            s_nxt.dat = s_r.moddis;
                            if (wb_we_i && !s_r.ctrl[`DCWB_BIT_MOD_LOCK]) begin
                                s_nxt.moddis = lane_merge(s_r.moddis, wb_dat_i, wb_sel_i);
                            end
                        end
                        `DCWB_OFF_PROG: s_nxt.dat = 32'h0;
                        default: begin
                            if (!is_word(wb_adr_i)) begin
                                s_nxt.err = 1'b1;
                            end
                        end
                    endcase
                end
            end
            DCWB_ACK: begin
                s_nxt.st = DCWB_IDLE;
            end
            default: s_nxt.st = DCWB_IDLE;
        endcase
        if (rst_i) begin
            s_nxt = '0;
            s_nxt.st = DCWB_IDLE;
            s_nxt.ctrl = `DCWB_CFG_CTRL_RST;
            s_nxt.key = `DCWB_KEY_RST;
            s_nxt.moddis = `DCWB_MODDIS_RST;
        end
    end

    always_ff @(posedge clk_i) begin
        s_r <= s_nxt;
    end

    // ****************************************
    // Outputs
    // ****************************************
    logic word_hit;
    assign word_hit = is_word(wb_adr_i);
    always_comb begin
        wb_dat_o = s_r.dat;
        if (word_hit && !s_r.err) begin
            wb_dat_o = word_view(wb_adr_i[3:2], mem_rd);
        end
    end
    assign wb_ack_o = (s_r.st == DCWB_ACK) && !s_r.err && wb_cyc_i && wb_stb_i;
    assign wb_err_o = (s_r.st == DCWB_ACK) && s_r.err && wb_cyc_i && wb_stb_i;
    assign ext_access_ok_o = s_r.ext_ok;
    assign boot_wr_ok_o = s_r.boot_ok;
    assign scan_port_enable_o = s_r.ctrl[`DCWB_BIT_CTRL_SCAN];
    assign pin_select_lock_o = s_r.ctrl[`DCWB_BIT_PIN_LOCK];
    assign test_out_drive_enable_o = s_r.ctrl[`DCWB_BIT_TDO_EN];
    assign module_disable_lock_o = s_r.ctrl[`DCWB_BIT_MOD_LOCK];
    assign module_disable_o = s_r.moddis;
    assign unlock_key_o = s_r.key;
endmodule // dcwb_bank
`default_nettype wire

// ---- dv/dcwb_bank_properties.sv ----
// Assertion checker of the configuration word bank
`timescale 1ns/1ns
`default_nettype none
`include "dcwb_consts.svh"
module dcwb_bank_checker (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic wb_cyc_i, // Cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_we_i, // Write
    input wire logic [15:0] wb_adr_i, // Address
    input wire logic wb_ack_o, // Ack
    input wire logic wb_err_o, // Error
    input wire logic prog_wr_i, // Program strobe
    input wire logic [1:0] prog_sel_i, // Word number
    input wire logic [31:0] prog_data_i, // Word value
    input wire logic ext_access_i, // Programmer request
    input wire logic boot_wr_req_i, // Boot write request
    input wire logic ext_access_ok_o, // Programmer grant
    input wire logic boot_wr_ok_o, // Boot write grant
    input wire logic scan_port_enable_o, // Scan enable
    input wire logic module_disable_lock_o, // Lock
    input wire logic [31:0] module_disable_o // Module disables
);
    logic cp_r, bwp_r, scan_r, one_r, seen_r, mapped;
    assign mapped = wb_adr_i == `DCWB_OFF_CFG_CTRL || wb_adr_i == `DCWB_OFF_IDENT
        || wb_adr_i == `DCWB_OFF_KEY || (wb_adr_i >= `DCWB_OFF_WORD0 && wb_adr_i <= `DCWB_OFF_PROG
        && wb_adr_i[1:0] == 2'b00);
    // Mirror of the programmed bits
    always_ff @(posedge clk_i) begin
        if (prog_wr_i && prog_sel_i == 2'h0) begin
            cp_r <= prog_data_i[`DCWB_BIT_CODE_PROT];
            bwp_r <= prog_data_i[`DCWB_BIT_BOOT_WP];
            scan_r <= prog_data_i[`DCWB_BIT_SCAN_EN];
            seen_r <= 1'b1;
        end
        if (prog_wr_i && prog_sel_i == 2'h3) begin
            one_r <= prog_data_i[`DCWB_BIT_ONE_SHOT];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence take_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    sequence lock_wr_s;
        take_s ##0 (module_disable_lock_o && wb_we_i && wb_adr_i == `DCWB_OFF_MODDIS);
    endsequence
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    AST_ANSWER: assert property (take_s |=> wb_ack_o != wb_err_o) else $error("no single answer");
    AST_ERR_MAP: assert property (wb_err_o |-> !mapped) else $error("err on mapped address");
    AST_ACK_MAP: assert property (wb_ack_o |-> mapped && wb_cyc_i && wb_stb_i)
        else $error("ack without mapped request");
    AST_CODE_PROT: assert property (!$past(rst_i) && $past(seen_r) |->
        ext_access_ok_o == ($past(ext_access_i) && $past(cp_r))) else $error("grant wrong");
    AST_BOOT_WP: assert property (!$past(rst_i) && $past(seen_r) |->
        boot_wr_ok_o == ($past(boot_wr_req_i) && $past(bwp_r))) else $error("boot grant wrong");
    AST_SCAN: assert property (!$past(rst_i) && $past(seen_r) |->
        scan_port_enable_o == $past(scan_r)) else $error("scan enable wrong");
    AST_MODDIS_LOCK: assert property (lock_wr_s |=>
        $stable(module_disable_o) ##1 $stable(module_disable_o)) else $error("locked write took");
    AST_ONE_SHOT: assert property (one_r && module_disable_lock_o |=> module_disable_lock_o)
        else $error("lock cleared");
endmodule // dcwb_bank_checker
bind dcwb_bank dcwb_bank_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_ack_o, .wb_err_o, .prog_wr_i, .prog_sel_i, .prog_data_i, .ext_access_i,
    .boot_wr_req_i, .ext_access_ok_o, .boot_wr_ok_o, .scan_port_enable_o,
    .module_disable_lock_o, .module_disable_o);
`default_nettype wire

// ---- dv/dcwb_bank_bench.sv ----
// Self-checking bench of the configuration word bank
`timescale 1ns/1ns
`default_nettype none
module dcwb_bank_bench;
    typedef struct packed {logic w; logic [15:0] a; logic [31:0] d; logic [31:0] e; logic r;} dcwb_row_t;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, prog_wr_i = 0;
    logic ext_access_i = 0, boot_wr_req_i = 0, got_err;
    logic [15:0] wb_adr_i = 16'h0000;
    logic [3:0] wb_sel_i = 4'hf;
    logic [1:0] prog_sel_i = 2'h0;
    logic [31:0] wb_dat_i = 32'h0, prog_data_i = 32'h0, rd;
    logic [31:0] wb_dat_o, module_disable_o, unlock_key_o, small_dat, rd_small;
    logic wb_ack_o, wb_err_o, ext_access_ok_o, boot_wr_ok_o, scan_port_enable_o;
    logic pin_select_lock_o, test_out_drive_enable_o, module_disable_lock_o;
    int miscompares = 0, compares = 0;
    dcwb_row_t rows [17] = '{
        '{1'b0, 16'hf200, 32'h0, 32'h0000000b, 1'b0}, '{1'b0, 16'hf220, 32'h0, 32'h20abcdef, 1'b0},
        '{1'b1, 16'hf230, 32'ha5a55a5a, 32'h0, 1'b0}, '{1'b0, 16'hf230, 32'h0, 32'ha5a55a5a, 1'b0},
        '{1'b1, 16'hf240, 32'h0, 32'h0, 1'b0}, '{1'b0, 16'hf240, 32'h0, 32'h7ff803e4, 1'b0},
        '{1'b0, 16'hf24c, 32'h0, 32'h00001234, 1'b0}, '{1'b0, 16'hf254, 32'h0, 32'h0, 1'b0},
        '{1'b1, 16'hf250, 32'hff, 32'h0, 1'b0}, '{1'b0, 16'hf250, 32'h0, 32'hff, 1'b0},
        '{1'b1, 16'hf200, 32'h1000, 32'h0, 1'b0}, '{1'b0, 16'hf200, 32'h0, 32'h00001008, 1'b0},
        '{1'b1, 16'hf250, 32'h0, 32'h0, 1'b0}, '{1'b0, 16'hf250, 32'h0, 32'hff, 1'b0},
        '{1'b0, 16'hf204, 32'h0, 32'h0, 1'b1},
        '{1'b0, 16'hf244, 32'h0, 32'h03dff7a7, 1'b0},
        '{1'b0, 16'hf248, 32'h0, 32'h00078777, 1'b0}};
    dcwb_bank #(.SILICON_VERSION(4'h2), .PART_CODE(28'h0abcdef), .BIG_FLASH(1'b1)) dut (
        .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .prog_wr_i, .prog_sel_i, .prog_data_i,
        .ext_access_i, .boot_wr_req_i, .ext_access_ok_o, .boot_wr_ok_o, .scan_port_enable_o,
        .pin_select_lock_o, .test_out_drive_enable_o, .module_disable_lock_o,
        .module_disable_o, .unlock_key_o);
    // Small flash variant, read back beside the main instance
    dcwb_bank #(.BIG_FLASH(1'b0)) dut_small (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o(small_dat), .wb_ack_o(), .wb_err_o(),
        .prog_wr_i, .prog_sel_i, .prog_data_i, .ext_access_i, .boot_wr_req_i,
        .ext_access_ok_o(), .boot_wr_ok_o(), .scan_port_enable_o(), .pin_select_lock_o(),
        .test_out_drive_enable_o(), .module_disable_lock_o(), .module_disable_o(),
        .unlock_key_o());
    initial forever #20 clk_i = ~clk_i;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task bus(input logic w, input logic [15:0] a, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (!(wb_ack_o || wb_err_o));
        rd = wb_dat_o;
        rd_small = small_dat;
        got_err = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task prog(input logic [1:0] s, input logic [31:0] v);
        prog_wr_i <= 1'b1;
        prog_sel_i <= s;
        prog_data_i <= v;
        @(posedge clk_i);
        prog_wr_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    task tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge clk_i);
        miscompares++;
        tally_and_finish;
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        prog(2'h0, 32'h7ff803e4);
        prog(2'h3, 32'h0fff1234);
        prog(2'h1, 32'hffffffff);
        prog(2'h2, 32'hffffffff);
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].d);
            chk(got_err, rows[i].r);
            if (!rows[i].w && !rows[i].r) chk(rd, rows[i].e);
        end
        ext_access_i <= 1'b1;
        boot_wr_req_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk(ext_access_ok_o, 1'b1);
        chk(boot_wr_ok_o, 1'b1);
        chk({scan_port_enable_o, module_disable_lock_o, pin_select_lock_o, test_out_drive_enable_o}, 4'hc);
        chk(unlock_key_o, 32'ha5a55a5a);
        prog(2'h0, 32'h6efffff8);
        chk({ext_access_ok_o, boot_wr_ok_o, scan_port_enable_o}, 3'h0);
        bus(1'b0, 16'hf240, 32'h0);
        chk(rd, 32'h6efffff8);
        chk(rd_small, 32'h6ef9fff8);
        bus(1'b1, 16'hf200, 32'h0);
        chk(module_disable_lock_o, 1'b0);
        prog(2'h3, 32'h10000000);
        bus(1'b1, 16'hf200, 32'h1000);
        bus(1'b1, 16'hf200, 32'h0);
        chk(module_disable_lock_o, 1'b1);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(1'b0, 16'hf200, 32'h0);
        chk(rd, 32'h00000003);
        chk(unlock_key_o, 32'h0);
        chk(module_disable_o, 32'h0);
        tally_and_finish;
    end
endmodule // dcwb_bank_bench
`default_nettype wire
